//--- src/intc_edge_enable.sv
`timescale 1ns/1ps
`include "intc_regs.svh"

// Notes on behaviour
// - vectors one to three stay unused; no source is ever given them
// - request flags clear by writing zero, or one to the clear register; writing one to the request register keeps them
// - edge select bits seven to five read as one, writes ignored
// - one edge select bit per pin: zero falling, one rising, reset zero
// - edge bits map to pins four..zero; shared pin functions follow selection
// - enable one bit seven gates timer A overflow
// - enable one bit six gates first serial transfer complete
// - enable one bit five gates all eight wakeup pins together
// - enable one bits four..zero gate external pins four..zero
// - enable bits: zero disables, one enables, all reset to zero
// - enable two bit seven gates direct transfer
// - enable two bit six gates converter end
// - enable two bits five..zero gate serial two, G, FH, FL, C, B
// - accepting an interrupt leaves its flag set until software clears
// - pin flag sets on selected edge while pin configured as interrupt
// - cpu mask high: flags still set, no interrupt accepted
module intc_edge_enable #(
    parameter int unsigned EXT_PINS  = 5,
    parameter int unsigned WAKE_PINS = 8
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       ce_i,
    // apb slave
    input  wire logic [17:0]                paddr_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // pins from outside
    input  wire logic [EXT_PINS-1:0]        ext_pin_i,
    input  wire logic [WAKE_PINS-1:0]       wakeup_pin_i,
    // same-clock inputs
    input  wire logic [EXT_PINS-1:0]        ext_pin_is_irq_i,
    input  wire intc_pkg::periph_events_t   periph_events_i,
    input  wire logic                       cpu_mask_i,
    // towards the cpu and peripherals
    output logic                            irq_o,
    output logic      [4:0]                 vec_num_o,
    output logic      [`SRC_COUNT-1:0]      int_req_o,
    output intc_pkg::shared_pin_events_t    shared_pin_events_o
);
    if (EXT_PINS != 5 || WAKE_PINS != 8) begin : g_bad_params
        $error("register layout serves exactly five ext pins and eight wakeup pins");
    end

    logic [4:0]            edge_sel_r;
    logic [7:0]            en_one_r;
    logic [7:0]            en_two_r;
    logic [7:0]            req_one_r;
    logic [7:0]            req_one_nxt;
    logic [7:0]            req_two_r;
    logic [7:0]            req_two_nxt;
    logic [7:0]            wake_req_r;
    logic [7:0]            wake_req_nxt;
    logic [31:0]           prdata_r;
    logic                  pslverr_r;
    logic                  irq_r;
    logic [4:0]            vec_r;
    logic [`SRC_COUNT-1:0] pend;
    logic [`SRC_COUNT-1:0] req_r;
    logic [4:0]            ext_edge;
    logic [7:0]            wake_edge;
    logic [7:0]            req_one_set;
    logic [7:0]            req_two_set;
    logic [15:0]           reg_idx;
    logic                  hit_edge;
    logic                  hit_en_one;
    logic                  hit_en_two;
    logic                  hit_req_one;
    logic                  hit_req_two;
    logic                  hit_wake;
    logic                  hit_clr_one;
    logic                  hit_clr_two;
    logic                  hit_clr_wake;
    logic                  hit_any;
    logic                  wr_acc;
    logic                  rd_setup;
    logic [7:0]            wdat;
    logic [7:0]            rd_mux;
    logic [7:0]            clr_one;
    logic [7:0]            clr_two;
    logic [7:0]            clr_wake;

    // pin synchronisers and edge detectors
    pin_edge_sense #(
        .WIDTH      (EXT_PINS),
        .IDLE_LEVEL (1'b1)
    ) u_ext_edge (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .pin_i      (ext_pin_i),
        .rise_sel_i (edge_sel_r),
        .edge_o     (ext_edge)
    );

    // wakeup pins are active low, falling edge only
    pin_edge_sense #(
        .WIDTH      (WAKE_PINS),
        .IDLE_LEVEL (1'b1)
    ) u_wake_edge (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .pin_i      (wakeup_pin_i),
        .rise_sel_i ('0),
        .edge_o     (wake_edge)
    );

    // apb decode
    assign reg_idx  = paddr_i[17:2];
    assign wdat     = pwdata_i[7:0];
    assign wr_acc   = ce_i & psel_i & penable_i & pwrite_i;
    assign rd_setup = ce_i & psel_i & ~penable_i & ~pwrite_i;

    always_comb begin
        hit_edge     = 1'b0;
        hit_en_one   = 1'b0;
        hit_en_two   = 1'b0;
        hit_req_one  = 1'b0;
        hit_req_two  = 1'b0;
        hit_wake     = 1'b0;
        hit_clr_one  = 1'b0;
        hit_clr_two  = 1'b0;
        hit_clr_wake = 1'b0;
        if (paddr_i[1:0] != 2'h0) begin
            hit_edge = 1'b0;
        end else if (reg_idx == `IDX_EDGE_SEL) begin
            hit_edge = 1'b1;
        end else if (reg_idx == `IDX_EN_ONE) begin
            hit_en_one = 1'b1;
        end else if (reg_idx == `IDX_EN_TWO) begin
            hit_en_two = 1'b1;
        end else if (reg_idx == `IDX_REQ_ONE) begin
            hit_req_one = 1'b1;
        end else if (reg_idx == `IDX_REQ_TWO) begin
            hit_req_two = 1'b1;
        end else if (reg_idx == `IDX_WAKE_REQ) begin
            hit_wake = 1'b1;
        end else if (reg_idx == `IDX_CLR_ONE) begin
            hit_clr_one = 1'b1;
        end else if (reg_idx == `IDX_CLR_TWO) begin
            hit_clr_two = 1'b1;
        end else if (reg_idx == `IDX_CLR_WAKE) begin
            hit_clr_wake = 1'b1;
        end
    end

    assign hit_any = hit_edge | hit_en_one | hit_en_two | hit_req_one | hit_req_two
                   | hit_wake | hit_clr_one | hit_clr_two | hit_clr_wake;

    // clear register reads as zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_edge) begin
            rd_mux = {`EDGE_FIXED_ONES, edge_sel_r};
        end else if (hit_en_one) begin
            rd_mux = en_one_r;
        end else if (hit_en_two) begin
            rd_mux = en_two_r;
        end else if (hit_req_one) begin
            rd_mux = req_one_r;
        end else if (hit_req_two) begin
            rd_mux = req_two_r;
        end else if (hit_wake) begin
            rd_mux = wake_req_r;
        end
    end

    // read data and error captured in setup, valid through access
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce_i && psel_i && !penable_i) begin
            prdata_r  <= rd_setup ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            pslverr_r <= ~hit_any;
        end
    end

    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r;
    assign pready_o  = 1'b1;

    // edge select: only bits four..zero are stored
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_sel_r <= 5'(`RST_EDGE_SEL & 8'h1f);
        end else if (wr_acc && hit_edge) begin
            edge_sel_r <= wdat[4:0];
        end
    end

    // enable registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_one_r <= `RST_EN;
            en_two_r <= `RST_EN;
        end else if (wr_acc) begin
            if (hit_en_one) begin
                en_one_r <= wdat;
            end
            if (hit_en_two) begin
                en_two_r <= wdat;
            end
        end
    end

    // set sources
    always_comb begin
        req_one_set = 8'h00;
        req_one_set[4:0] = ext_edge & ext_pin_is_irq_i;
        req_one_set[`BIT_TIMER_A] = periph_events_i.timer_a;
        req_one_set[`BIT_SERIAL1] = periph_events_i.serial1;
        req_two_set[`BIT_DXFER] = periph_events_i.dxfer;
        req_two_set[`BIT_ADC] = periph_events_i.adc;
        req_two_set[`BIT_SERIAL2] = periph_events_i.serial2;
        req_two_set[`BIT_TIMER_G] = periph_events_i.timer_g;
        req_two_set[`BIT_TIMER_FH] = periph_events_i.timer_fh;
        req_two_set[`BIT_TIMER_FL] = periph_events_i.timer_fl;
        req_two_set[`BIT_TIMER_C] = periph_events_i.timer_c;
        req_two_set[`BIT_TIMER_B] = periph_events_i.timer_b;
    end

    // zero in the request register, or one in the clear register, clears
    assign clr_one  = (wr_acc & hit_req_one) ? ~wdat : ((wr_acc & hit_clr_one) ? wdat : 8'h00);
    assign clr_two  = (wr_acc & hit_req_two) ? ~wdat : ((wr_acc & hit_clr_two) ? wdat : 8'h00);
    assign clr_wake = (wr_acc & hit_wake) ? ~wdat : ((wr_acc & hit_clr_wake) ? wdat : 8'h00);

    // a set in the cycle of a clear wins; nothing clears on acceptance
    assign req_one_nxt  = (req_one_r & ~clr_one) | req_one_set | `REQ_ONE_FIXED;
    assign req_two_nxt  = (req_two_r & ~clr_two) | req_two_set;
    assign wake_req_nxt = (wake_req_r & ~clr_wake) | wake_edge;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_one_r  <= `RST_REQ_ONE;
            req_two_r  <= `RST_REQ;
            wake_req_r <= `RST_REQ;
        end else if (ce_i) begin
            req_one_r  <= req_one_nxt;
            req_two_r  <= req_two_nxt;
            wake_req_r <= wake_req_nxt;
        end
    end

    // shared pin functions see the same selected edge
    assign shared_pin_events_o.adc_trigger_in   = ext_edge[`PIN_ADC_TRIG];
    assign shared_pin_events_o.timer_f_event_in = ext_edge[`PIN_TIMER_F];
    assign shared_pin_events_o.timer_c_event_in = ext_edge[`PIN_TIMER_C];
    assign shared_pin_events_o.timer_b_event_in = ext_edge[`PIN_TIMER_B];

    // gated requests
    always_comb begin
        pend[4:0] = req_one_r[4:0] & en_one_r[4:0];
        pend[`SRC_WAKEUP] = (|wake_req_r) & en_one_r[`BIT_WAKEUP];
        pend[`SRC_SERIAL1] = req_one_r[`BIT_SERIAL1] & en_one_r[`BIT_SERIAL1];
        pend[`SRC_TIMER_A] = req_one_r[`BIT_TIMER_A] & en_one_r[`BIT_TIMER_A];
        pend[`SRC_TIMER_B] = req_two_r[`BIT_TIMER_B] & en_two_r[`BIT_TIMER_B];
        pend[`SRC_TIMER_C] = req_two_r[`BIT_TIMER_C] & en_two_r[`BIT_TIMER_C];
        pend[`SRC_TIMER_FL] = req_two_r[`BIT_TIMER_FL] & en_two_r[`BIT_TIMER_FL];
        pend[`SRC_TIMER_FH] = req_two_r[`BIT_TIMER_FH] & en_two_r[`BIT_TIMER_FH];
        pend[`SRC_TIMER_G] = req_two_r[`BIT_TIMER_G] & en_two_r[`BIT_TIMER_G];
        pend[`SRC_SERIAL2] = req_two_r[`BIT_SERIAL2] & en_two_r[`BIT_SERIAL2];
        pend[`SRC_ADC] = req_two_r[`BIT_ADC] & en_two_r[`BIT_ADC];
        pend[`SRC_DXFER] = req_two_r[`BIT_DXFER] & en_two_r[`BIT_DXFER];
    end

    // vector numbers start above the reserved slots
    function automatic logic [4:0] vec_of(input int unsigned src);
        if (src == `SRC_ADC) begin
            return `VEC_ADC;
        end else if (src == `SRC_DXFER) begin
            return `VEC_DXFER;
        end
        return `VEC_FIRST_EXT + 5'(src);
    endfunction

    // lowest index wins
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_r <= 1'b0;
            vec_r <= `VEC_NONE;
            req_r <= '0;
        end else if (ce_i) begin
            irq_r <= (|pend) & ~cpu_mask_i;
            req_r <= pend;
            vec_r <= `VEC_NONE;
            for (int i = `SRC_COUNT - 1; i >= 0; i--) begin
                if (pend[i]) begin
                    vec_r <= vec_of(i);
                end
            end
        end
    end

    assign irq_o     = irq_r;
    assign vec_num_o = vec_r;
    assign int_req_o = req_r;

    property p_vec_not_reserved;
        @(posedge clk_i) disable iff (reset_i)
        !(vec_num_o >= `VEC_RSVD_LO && vec_num_o <= `VEC_RSVD_HI);
    endproperty
    a_vec_not_reserved: assert property (p_vec_not_reserved)
        else $error("vector in reserved range");

    property p_write_one_keeps;
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && hit_req_two && wdat == 8'hff) |=> ((req_two_r & $past(req_two_r)) == $past(req_two_r));
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("writing one cleared a request flag");

    property p_edge_fixed_ones;
        @(posedge clk_i) disable iff (reset_i)
        (rd_setup && hit_edge) |=> (prdata_o[7:5] == `EDGE_FIXED_ONES);
    endproperty
    a_edge_fixed_ones: assert property (p_edge_fixed_ones)
        else $error("edge select upper bits not read as one");

    property p_enable_holds;
        @(posedge clk_i) disable iff (reset_i)
        !(wr_acc && hit_en_one) |=> $stable(en_one_r);
    endproperty
    a_enable_holds: assert property (p_enable_holds)
        else $error("enable register changed without a write");

    property p_flag_sticky;
        @(posedge clk_i) disable iff (reset_i)
        !(wr_acc && (hit_req_one || hit_clr_one)) |=> ((req_one_r & $past(req_one_r)) == $past(req_one_r));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("request flag dropped without software clear");

    property p_ext_flag_set;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && ext_edge[0] && ext_pin_is_irq_i[0]) |=> req_one_r[0];
    endproperty
    a_ext_flag_set: assert property (p_ext_flag_set)
        else $error("pin edge did not set its flag");

    property p_mask_blocks;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && cpu_mask_i) |=> !irq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("interrupt raised while cpu mask set");

    property p_irq_raised;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !cpu_mask_i && req_one_r[`BIT_TIMER_A] && en_one_r[`BIT_TIMER_A]) |=> irq_o;
    endproperty
    a_irq_raised: assert property (p_irq_raised)
        else $error("enabled pending timer A request not raised");

    property p_disabled_silent;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && en_one_r == 8'h00 && en_two_r == 8'h00) |=> !irq_o;
    endproperty
    a_disabled_silent: assert property (p_disabled_silent)
        else $error("interrupt raised with all enables zero");
endmodule

//--- pkg/intc_regs.svh
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// register indices, byte address is four times the index
`define IDX_EDGE_SEL     16'hfff2
`define IDX_EN_ONE       16'hfff3
`define IDX_EN_TWO       16'hfff4
`define IDX_REQ_ONE      16'hfff6
`define IDX_REQ_TWO      16'hfff7
`define IDX_WAKE_REQ     16'hfff9
`define IDX_CLR_ONE      16'hfffa
`define IDX_CLR_TWO      16'hfffb
`define IDX_CLR_WAKE     16'hfffc

// reset values and fixed bits
`define RST_EDGE_SEL     8'he0
`define RST_EN           8'h00
`define RST_REQ_ONE      8'h20
`define RST_REQ          8'h00
`define EDGE_FIXED_ONES  3'h7
`define REQ_ONE_FIXED    8'h20

// field positions
`define BIT_TIMER_A      7
`define BIT_SERIAL1      6
`define BIT_WAKEUP       5
`define BIT_DXFER        7
`define BIT_ADC          6
`define BIT_SERIAL2      5
`define BIT_TIMER_G      4
`define BIT_TIMER_FH     3
`define BIT_TIMER_FL     2
`define BIT_TIMER_C      1
`define BIT_TIMER_B      0
`define PIN_ADC_TRIG     4
`define PIN_TIMER_F      3
`define PIN_TIMER_C      2
`define PIN_TIMER_B      1

// pending source positions, highest priority first
`define SRC_COUNT        16
`define SRC_WAKEUP       5
`define SRC_SERIAL1      6
`define SRC_TIMER_A      7
`define SRC_TIMER_B      8
`define SRC_TIMER_C      9
`define SRC_TIMER_FL     10
`define SRC_TIMER_FH     11
`define SRC_TIMER_G      12
`define SRC_SERIAL2      13
`define SRC_ADC          14
`define SRC_DXFER        15

// vector numbers
`define VEC_NONE         5'h00
`define VEC_FIRST_EXT    5'h04
`define VEC_RSVD_LO      5'h01
`define VEC_RSVD_HI      5'h03
`define VEC_ADC          5'h13
`define VEC_DXFER        5'h14

`endif

//--- pkg/intc_pkg.sv
package intc_pkg;

    // one-cycle event pulses from on-chip peripherals
    typedef struct packed {
        logic timer_a;
        logic serial1;
        logic dxfer;
        logic adc;
        logic serial2;
        logic timer_g;
        logic timer_fh;
        logic timer_fl;
        logic timer_c;
        logic timer_b;
    } periph_events_t;

    // selected-edge pulses handed to the functions sharing ext pins 4..1
    typedef struct packed {
        logic adc_trigger_in;
        logic timer_f_event_in;
        logic timer_c_event_in;
        logic timer_b_event_in;
    } shared_pin_events_t;

endpackage

//--- src/pin_edge_sense.sv
`timescale 1ns/1ps
module pin_edge_sense #(
    parameter int unsigned WIDTH      = 5,
    parameter logic        IDLE_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    // pins and edge choice
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] rise_sel_i,
    // one-cycle pulse per detected edge
    output logic      [WIDTH-1:0] edge_o
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_edge_sense needs at least one pin");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        logic meta_r;
        logic sync_r;
        logic prev_r;
        logic edge_r;

        // meta_r feeds sync_r only
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                meta_r <= IDLE_LEVEL;
                sync_r <= IDLE_LEVEL;
                prev_r <= IDLE_LEVEL;
            end else if (ce_i) begin
                meta_r <= pin_i[i];
                sync_r <= meta_r;
                prev_r <= sync_r;
            end
        end

        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                edge_r <= 1'b0;
            end else if (ce_i) begin
                edge_r <= rise_sel_i[i] ? (sync_r & ~prev_r) : (~sync_r & prev_r);
            end
        end

        assign edge_o[i] = edge_r;
    end
endmodule

//--- tb/event_model.sv
`timescale 1ns/1ps
module event_model (
    // clock
    input  wire logic                clk_i,
    // peripheral pulses and pins towards the block
    output intc_pkg::periph_events_t ev_o,
    output logic [4:0]               ext_o,
    output logic [7:0]               wake_o
);
    // pins idle high as with pull-ups
    initial begin
        ev_o   = '0;
        ext_o  = 5'h1f;
        wake_o = 8'hff;
    end

    task automatic pulse(input int i);
        @(posedge clk_i);
        ev_o <= intc_pkg::periph_events_t'(10'h001 << i);
        @(posedge clk_i);
        ev_o <= '0;
    endtask

    task automatic pins(input logic [4:0] e, input logic [7:0] w);
        @(posedge clk_i);
        ext_o  <= e;
        wake_o <= w;
    endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "intc_regs.svh"
module tb_top;
    logic                         clk_i      = 1'b0;
    logic                         reset_i    = 1'b1;
    logic [17:0]                  paddr      = '0;
    logic                         psel       = 1'b0;
    logic                         penable    = 1'b0;
    logic                         pwrite     = 1'b0;
    logic [31:0]                  pwdata     = '0;
    logic                         cpu_mask   = 1'b0;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [4:0]                   ext_pin;
    logic [7:0]                   wake_pin;
    logic                         irq;
    logic [4:0]                   vec;
    logic [15:0]                  int_req;
    intc_pkg::periph_events_t     ev;
    intc_pkg::shared_pin_events_t shared;
    int                           fails      = 0;
    int                           compares   = 0;
    int                           cycles     = 0;
    logic [31:0]                  rd;
    logic                         err;
    logic [7:0]                   v;
    logic                         s;
    logic [2:0]                   w;
    logic [4:0]                   pin_irq    = 5'h1f;
    logic [3:0]                   shared_seen = 4'h0;

    event_model model (.clk_i(clk_i), .ev_o(ev), .ext_o(ext_pin), .wake_o(wake_pin));

    intc_edge_enable dut (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ext_pin_i(ext_pin), .wakeup_pin_i(wake_pin), .ext_pin_is_irq_i(pin_irq),
        .periph_events_i(ev), .cpu_mask_i(cpu_mask), .irq_o(irq), .vec_num_o(vec),
        .int_req_o(int_req), .shared_pin_events_o(shared)
    );

    always #25 clk_i = ~clk_i;

    // sticky record of shared pin pulses
    always @(posedge clk_i) begin
        if (!reset_i) begin
            shared_seen <= shared_seen | shared;
        end
    end

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h0, exp}, what);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // sources by event struct bit: 9 timer a, 8 serial one, 7..0 enable two order
    function automatic logic [15:0] reg_of(input int i, input logic req);
        if (i >= 8) return req ? `IDX_REQ_ONE : `IDX_EN_ONE;
        return req ? `IDX_REQ_TWO : `IDX_EN_TWO;
    endfunction
    function automatic logic [7:0] bit_of(input int i);
        return (i >= 8) ? (8'h01 << (i - 2)) : (8'h01 << i);
    endfunction
    function automatic logic [7:0] base_of(input int i);
        return (i >= 8) ? 8'h20 : 8'h00;
    endfunction
    function automatic logic [31:0] src_of(input int i);
        return (i >= 8) ? 32'h1 << (i - 2) : 32'h1 << (i + 8);
    endfunction
    function automatic logic [31:0] vec_of(input int i);
        if (i >= 8) return 32'(i + 2);
        if (i >= 6) return 32'(i + 13);
        return 32'(i + 12);
    endfunction

    initial begin
        void'($urandom(1963));
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        rchk(`IDX_EDGE_SEL, 8'he0, "edge rst");
        rchk(`IDX_EN_ONE, 8'h00, "en1 rst");
        rchk(`IDX_EN_TWO, 8'h00, "en2 rst");
        rchk(`IDX_REQ_ONE, 8'h20, "req1 rst");
        rchk(`IDX_REQ_TWO, 8'h00, "req2 rst");
        rchk(`IDX_WAKE_REQ, 8'h00, "wake rst");
        for (int k = 0; k < 6; k++) begin
            v = 8'($urandom);
            apb(1'b1, `IDX_EDGE_SEL, v);
            rchk(`IDX_EDGE_SEL, v | 8'he0, "edge rw");
            apb(1'b1, (k % 2) ? `IDX_EN_TWO : `IDX_EN_ONE, v);
            rchk((k % 2) ? `IDX_EN_TWO : `IDX_EN_ONE, v, "en rw");
        end
        apb(1'b1, `IDX_EN_ONE, 8'h00);
        apb(1'b1, `IDX_EN_TWO, 8'h00);
        apb(1'b0, 16'hfff5, 8'h00);
        check({31'h0, err}, 32'h1, "unmapped err");
        check(rd, 32'h0, "unmapped data");
        $display("test registers done");
        for (int i = 0; i < 10; i++) begin
            model.pulse(i);
            wait_cyc(2);
            rchk(reg_of(i, 1'b1), base_of(i) | bit_of(i), "flag");
            check({31'h0, irq}, 32'h0, "off irq");
            apb(1'b1, reg_of(i, 1'b0), bit_of(i));
            wait_cyc(2);
            check({31'h0, irq}, 32'h1, "on irq");
            check({16'h0, int_req}, src_of(i), "int req");
            check({27'h0, vec}, vec_of(i), "vector");
            @(posedge clk_i);
            cpu_mask <= 1'b1;
            wait_cyc(2);
            check({31'h0, irq}, 32'h0, "mask irq");
            @(posedge clk_i);
            cpu_mask <= 1'b0;
            apb(1'b1, reg_of(i, 1'b1), 8'hff);
            rchk(reg_of(i, 1'b1), base_of(i) | bit_of(i), "one keeps");
            apb(1'b1, reg_of(i, 1'b1), ~bit_of(i));
            rchk(reg_of(i, 1'b1), base_of(i), "zero clears");
            apb(1'b1, reg_of(i, 1'b0), 8'h00);
        end
        model.pulse(9);
        apb(1'b1, `IDX_CLR_ONE, 8'h80);
        rchk(`IDX_REQ_ONE, 8'h20, "clear reg");
        rchk(`IDX_CLR_ONE, 8'h00, "clear reads 0");
        model.pulse(0);
        apb(1'b1, `IDX_CLR_TWO, 8'h01);
        rchk(`IDX_REQ_TWO, 8'h00, "clear two");
        $display("test sources done");
        apb(1'b1, `IDX_EN_ONE, 8'h1f);
        for (int p = 0; p < 5; p++) begin
            s = 1'($urandom);
            apb(1'b1, `IDX_EDGE_SEL, {3'h0, 5'(s) << p});
            model.pins(5'h1f ^ (5'(s) << p), 8'hff);
            wait_cyc(6);
            rchk(`IDX_REQ_ONE, 8'h20, "other edge");
            model.pins(5'h1f ^ (5'(!s) << p), 8'hff);
            wait_cyc(6);
            rchk(`IDX_REQ_ONE, 8'h20 | (8'h01 << p), "pin flag");
            check({16'h0, int_req}, 32'h1 << p, "pin req");
            check({28'h0, shared_seen}, 32'((1 << p) - 1), "shared ev");
            model.pins(5'h1f, 8'hff);
            wait_cyc(6);
            apb(1'b1, `IDX_REQ_ONE, ~(8'h01 << p));
            rchk(`IDX_REQ_ONE, 8'h20, "pin clear");
        end
        @(posedge clk_i);
        pin_irq <= 5'h00;
        model.pins(5'h00, 8'hff);
        wait_cyc(6);
        model.pins(5'h1f, 8'hff);
        wait_cyc(6);
        rchk(`IDX_REQ_ONE, 8'h20, "not irq pin");
        $display("test pins done");
        w = 3'($urandom);
        apb(1'b1, `IDX_EN_ONE, 8'h20);
        model.pins(5'h1f, ~(8'h01 << w));
        wait_cyc(6);
        rchk(`IDX_WAKE_REQ, 8'h01 << w, "wake flag");
        check({16'h0, int_req}, 32'h20, "wake req");
        check({31'h0, irq}, 32'h1, "wake irq");
        model.pins(5'h1f, 8'hff);
        apb(1'b1, `IDX_WAKE_REQ, 8'h00);
        rchk(`IDX_WAKE_REQ, 8'h00, "wake clear");
        model.pins(5'h1f, ~(8'h01 << w));
        wait_cyc(6);
        apb(1'b1, `IDX_CLR_WAKE, 8'h01 << w);
        rchk(`IDX_WAKE_REQ, 8'h00, "wake clr reg");
        model.pins(5'h1f, 8'hff);
        $display("test wakeup done");
        complete_run();
    end
endmodule
